// file: include/omed_regs.vh
// register map, field positions, reset values and time steps of the
// orientation and motion event detector; definitions only
`ifndef OMED_REGS_VH
`define OMED_REGS_VH

// register offsets on the byte register port
`define OMED_ADDR_ORIENT_CONFIG 8'h11
`define OMED_ADDR_ORIENT_DEBOUNCE_COUNT 8'h12
`define OMED_ADDR_TILT_TRIP_ANGLES 8'h13
`define OMED_ADDR_ORIENT_THRESHOLD_HYST 8'h14
`define OMED_ADDR_MOTION_CONFIG 8'h15
`define OMED_ADDR_MOTION_SOURCE 8'h16
`define OMED_ADDR_MOTION_THRESHOLD 8'h17
`define OMED_ADDR_MOTION_DEBOUNCE_COUNT 8'h18

// orient_config fields and reset value
`define OMED_OCFG_DBMODE 7
`define OMED_OCFG_EN 6
`define OMED_OCFG_RESET 8'h80
`define OMED_ODBC_RESET 8'h00

// fixed angle codes
`define OMED_BACK_FRONT_TRIP_CODE_CODE 2'h1
`define OMED_Z_TILT_LOCKOUT_CODE_CODE 3'h4
`define OMED_PL_THS_CODE 5'h10
`define OMED_HYS_CODE 3'h4

// motion_config fields
`define OMED_MCFG_LATCH 7
`define OMED_MCFG_OR 6
`define OMED_MCFG_ZEN 5
`define OMED_MCFG_YEN 4
`define OMED_MCFG_XEN 3
`define OMED_MCFG_RESET 8'h00

// motion_source and motion_threshold fields
`define OMED_MSRC_EA 7
`define OMED_MTHS_DBMODE 7
`define OMED_MTHS_RESET 8'h00
`define OMED_MDBC_RESET 8'h00

// oversampling modes
`define OMED_OSR_NORMAL 2'h0
`define OMED_OSR_LNLP 2'h1
`define OMED_OSR_HIRES 2'h2
`define OMED_OSR_LP 2'h3

// rate codes: 0=800 1=400 2=200 3=100 4=50 5=12.5 6=6.25 7=1.56 Hz
`define OMED_RATE_800 3'h0
`define OMED_RATE_400 3'h1
`define OMED_RATE_200 3'h2
`define OMED_RATE_100 3'h3
`define OMED_RATE_12P5 3'h5

// debounce time steps in units of 0.25 ms
`define OMED_STEP_1P25MS 10'h005
`define OMED_STEP_2P5MS 10'h00a
`define OMED_STEP_5MS 10'h014
`define OMED_STEP_10MS 10'h028
`define OMED_STEP_20MS 10'h050
`define OMED_STEP_80MS 10'h140
`define OMED_STEP_160MS 10'h280

`endif

// file: hw/omed_debounce.v
// up/down debounce counter advanced once per output sample
// assumes i_tick is a one-cycle pulse per completed sample
`timescale 1ns/1ps

module omed_debounce (
   input wire i_clk_sys,
   input wire i_reset,
   input wire i_tick,
   input wire i_cond,
   input wire i_dec_mode,
   input wire [7:0] i_limit,
   input wire i_clear,
   output wire [7:0] o_next_count,
   output reg [7:0] o_count
);

   reg [7:0] next_count;

   // count up while the condition holds, saturating at the limit
   always @* begin
      next_count = o_count;
      if (i_clear) begin
         next_count = 8'h00;
      end else if (i_tick) begin
         if (i_cond) begin
            if (o_count < i_limit) begin
               next_count = o_count + 8'h01;
            end
         end else if (i_dec_mode) begin
            next_count = 8'h00;
         end else if (o_count != 8'h00) begin
            next_count = o_count - 8'h01;
         end
      end
   end

   assign o_next_count = next_count;

   // state changes only on a sample tick or a clear
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_count <= 8'h00;
      end else begin
         o_count <= next_count;
      end
   end

endmodule

// file: hw/omed_top.v
// orientation and freefall/motion event detector with byte registers
// assumes one-cycle sample ticks and signed 8-bit axis samples that
// are synchronous to i_clk_sys; reads and writes are one-cycle strobes
//
// Functional notes
// - Debounce mode 0 decrements, 1 clears; orientation bit resets 1.
// - Orientation detection runs only while enabled; enable resets 0.
// - 8-bit orientation count, reset zero, delays state changes.
// - Any wake/sleep change resets the orientation debounce counter.
// - Normal step 1.25/2.5/5/10 ms, 20 ms at 50 Hz and below.
// - Slow rates: low-noise 80, low-power 80/160, high-res 2.5 ms.
// - Back/front trip code fixed at 01 in bits 7:6.
// - Z-tilt lockout code fixed at 100 in bits 2:0.
// - Portrait/landscape threshold code fixed 1_0000 in bits 7:3.
// - Hysteresis code fixed 100; trips at 59 and 31 degrees.
// - Combine bit 6: 0 ANDs axes (freefall), 1 ORs (motion).
// - Only enabled axes count; none enabled disables the detector.
// - Event-active flag sets only after motion debounce completes.
// - Unlatched, mode 0: flag held until counter counts back down.
// - Freefall unlatched mode 1: clear at end, re-set after delay.
// - Motion unlatched mode 1: clear as soon as high condition ends.
// - Unlatched: source read clears nothing and keeps the counter.
// - Unheld axis flags follow the undebounced high comparison.
// - Latched: flag held until read; new event needs full delay.
// - Latched read clears flag and counter; in motion mode all bits.
// - Latched: axis flags frozen while flag set, until source read.
// - Magnitude vs 7-bit threshold: freefall at/below, motion above.
// - Polarity 0 positive, 1 negative; zero when axis disabled.
`timescale 1ns/1ps
`include "omed_regs.vh"

module omed_top (
   input wire i_clk_sys,
   input wire i_reset,
   input wire [7:0] i_reg_addr,
   input wire i_reg_wr,
   input wire [7:0] i_reg_wdata,
   input wire i_reg_rd,
   output reg [7:0] o_reg_rdata,
   input wire i_sample_tick,
   input wire signed [7:0] i_x_accel,
   input wire signed [7:0] i_y_accel,
   input wire signed [7:0] i_z_accel,
   input wire i_sleep_state,
   input wire [1:0] i_osr_mode,
   input wire [2:0] i_output_sample_rate,
   output reg [9:0] o_orient_step,
   output reg [1:0] o_orient_lapo,
   output reg o_orient_back,
   output reg o_orient_lockout,
   output reg o_orient_change,
   output wire o_event_active
);

   // magnitude of a signed sample, 7 bits (-128 saturates)
   function [6:0] omed_mag;
      input [7:0] v;
      reg [7:0] t;
      begin
         t = v[7] ? (8'h00 - v) : v;
         omed_mag = t[7] ? 7'h7f : t[6:0];
      end
   endfunction

   // debounce time step in 0.25 ms units for a mode and rate
   function [9:0] omed_step;
      input [1:0] osr;
      input [2:0] rate;
      reg [9:0] base;
      begin
         case (rate)
            `OMED_RATE_800: base = `OMED_STEP_1P25MS;
            `OMED_RATE_400: base = `OMED_STEP_2P5MS;
            `OMED_RATE_200: base = `OMED_STEP_5MS;
            `OMED_RATE_100: base = `OMED_STEP_10MS;
            default: base = `OMED_STEP_20MS;
         endcase
         case (osr)
            `OMED_OSR_HIRES: begin
               omed_step = (rate == `OMED_RATE_800) ? base :
                  `OMED_STEP_2P5MS;
            end
            `OMED_OSR_LNLP: begin
               omed_step = (rate >= `OMED_RATE_12P5) ? `OMED_STEP_80MS :
                  base;
            end
            `OMED_OSR_LP: begin
               if (rate == `OMED_RATE_12P5) begin
                  omed_step = `OMED_STEP_80MS;
               end else if (rate > `OMED_RATE_12P5) begin
                  omed_step = `OMED_STEP_160MS;
               end else begin
                  omed_step = base;
               end
            end
            default: omed_step = base;
         endcase
      end
   endfunction

   // software registers
   reg [7:0] orient_config;
   reg [7:0] orient_debounce_count;
   reg [7:0] motion_config;
   reg [7:0] motion_threshold;
   reg [7:0] motion_debounce_count;
   reg [7:0] motion_source;
   reg sleep_q;

   wire [7:0] tilt_trip_angles;
   wire [7:0] orient_threshold_hyst;
   wire orient_detect_en;
   wire event_latch_en;
   wire combine_or_select;
   wire [2:0] axis_en;
   wire src_read;
   wire wr_hit;

   assign orient_detect_en = orient_config[`OMED_OCFG_EN];
   assign event_latch_en = motion_config[`OMED_MCFG_LATCH];
   assign combine_or_select = motion_config[`OMED_MCFG_OR];
   assign axis_en = {motion_config[`OMED_MCFG_ZEN],
      motion_config[`OMED_MCFG_YEN], motion_config[`OMED_MCFG_XEN]};
   assign src_read = i_reg_rd && (i_reg_addr == `OMED_ADDR_MOTION_SOURCE);
   assign wr_hit = i_reg_wr;

   // fixed angle codes; writes to these registers are ignored
   assign tilt_trip_angles = {`OMED_BACK_FRONT_TRIP_CODE_CODE, 3'h0,
      `OMED_Z_TILT_LOCKOUT_CODE_CODE};
   assign orient_threshold_hyst = {`OMED_PL_THS_CODE,
      `OMED_HYS_CODE};

   // register writes
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         orient_config <= `OMED_OCFG_RESET;
         orient_debounce_count <= `OMED_ODBC_RESET;
         motion_config <= `OMED_MCFG_RESET;
         motion_threshold <= `OMED_MTHS_RESET;
         motion_debounce_count <= `OMED_MDBC_RESET;
      end else if (wr_hit) begin
         case (i_reg_addr)
            `OMED_ADDR_ORIENT_CONFIG: begin
               orient_config <= {i_reg_wdata[7:6], 6'h00};
            end
            `OMED_ADDR_ORIENT_DEBOUNCE_COUNT: begin
               orient_debounce_count <= i_reg_wdata;
            end
            `OMED_ADDR_MOTION_CONFIG: begin
               motion_config <= {i_reg_wdata[7:3], 3'h0};
            end
            `OMED_ADDR_MOTION_THRESHOLD: begin
               motion_threshold <= i_reg_wdata;
            end
            `OMED_ADDR_MOTION_DEBOUNCE_COUNT: begin
               motion_debounce_count <= i_reg_wdata;
            end
            default: begin
               motion_threshold <= motion_threshold;
            end
         endcase
      end
   end

   // register reads, answered one cycle after the strobe
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            `OMED_ADDR_ORIENT_CONFIG: o_reg_rdata <= orient_config;
            `OMED_ADDR_ORIENT_DEBOUNCE_COUNT: begin
               o_reg_rdata <= orient_debounce_count;
            end
            `OMED_ADDR_TILT_TRIP_ANGLES: o_reg_rdata <= tilt_trip_angles;
            `OMED_ADDR_ORIENT_THRESHOLD_HYST: begin
               o_reg_rdata <= orient_threshold_hyst;
            end
            `OMED_ADDR_MOTION_CONFIG: o_reg_rdata <= motion_config;
            `OMED_ADDR_MOTION_SOURCE: begin
               // disabled axes read zero whatever was captured
               o_reg_rdata <= motion_source & {2'h3, {2{axis_en[2]}},
                  {2{axis_en[1]}}, {2{axis_en[0]}}};
            end
            `OMED_ADDR_MOTION_THRESHOLD: o_reg_rdata <= motion_threshold;
            `OMED_ADDR_MOTION_DEBOUNCE_COUNT: begin
               o_reg_rdata <= motion_debounce_count;
            end
            default: o_reg_rdata <= 8'h00;
         endcase
      end
   end

   // debounce step follows the current rate and oversampling mode
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_orient_step <= `OMED_STEP_1P25MS;
      end else begin
         o_orient_step <= omed_step(i_osr_mode,
            i_output_sample_rate);
      end
   end

   // per-axis magnitude and threshold comparison
   wire [6:0] mag_x;
   wire [6:0] mag_y;
   wire [6:0] mag_z;
   wire [2:0] axis_high;
   wire [2:0] axis_neg;
   assign mag_x = omed_mag(i_x_accel);
   assign mag_y = omed_mag(i_y_accel);
   assign mag_z = omed_mag(i_z_accel);
   assign axis_neg = {i_z_accel[7], i_y_accel[7], i_x_accel[7]};
   assign axis_high = {mag_z > motion_threshold[6:0],
      mag_y > motion_threshold[6:0],
      mag_x > motion_threshold[6:0]};

   // orientation candidate from the ratio of axes; ratios in eighths
   // approximate tan 31 and tan 59, trading up to about one degree
   // for multiplier-free compares
   wire [10:0] x8;
   wire [10:0] y8;
   wire [10:0] x5;
   wire [10:0] x13;
   wire [10:0] z5;
   wire [10:0] max9;
   wire [10:0] z4;
   wire [6:0] mag_max;
   reg [1:0] cand_lapo;
   wire cand_back;
   wire cand_lock;
   assign x8 = {1'b0, mag_x, 3'h0};
   assign y8 = {1'b0, mag_y, 3'h0};
   assign x5 = {4'h0, mag_x} * 11'd5;
   assign x13 = {4'h0, mag_x} * 11'd13;
   assign z5 = {4'h0, mag_z} * 11'd5;
   assign z4 = {2'h0, mag_z, 2'h0};
   assign mag_max = (mag_x > mag_y) ? mag_x : mag_y;
   assign max9 = {4'h0, mag_max} * 11'd9;
   assign cand_back = i_z_accel[7] && (z4 > {4'h0, mag_max});
   assign cand_lock = z5 > max9;

   // landscape leaves at 59 deg, portrait leaves at 31 deg
   always @* begin
      cand_lapo = o_orient_lapo;
      if (o_orient_lapo[1]) begin
         if (y8 > x13) begin
            cand_lapo = {1'b0, i_y_accel[7]};
         end else begin
            cand_lapo = {1'b1, i_x_accel[7]};
         end
      end else begin
         if (y8 < x5) begin
            cand_lapo = {1'b1, i_x_accel[7]};
         end else begin
            cand_lapo = {1'b0, i_y_accel[7]};
         end
      end
   end

   // orientation debounce; cleared on disable, commit or power change
   wire orient_differs;
   wire orient_clear;
   wire orient_commit;
   wire [7:0] orient_cnt;
   assign orient_differs = cand_lock ? !o_orient_lockout :
      (o_orient_lockout || (cand_lapo != o_orient_lapo) ||
      (cand_back != o_orient_back));
   // commit on the sample that would bring the count to the limit; taken
   // from the stored count so the clear below cannot feed back into it
   assign orient_commit = orient_detect_en && i_sample_tick &&
      orient_differs && ({1'b0, orient_cnt} + 9'h001 >=
      {1'b0, orient_debounce_count});
   assign orient_clear = !orient_detect_en ||
      (i_sleep_state != sleep_q);

   omed_debounce u_orient_db (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_tick(i_sample_tick),
      .i_cond(orient_differs),
      .i_dec_mode(orient_config[`OMED_OCFG_DBMODE]),
      .i_limit(orient_debounce_count),
      .i_clear(orient_clear || orient_commit),
      .o_next_count(),
      .o_count(orient_cnt)
   );

   // orientation state, updated only on a debounced sample
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         sleep_q <= 1'b0;
         o_orient_lapo <= 2'h0;
         o_orient_back <= 1'b0;
         o_orient_lockout <= 1'b0;
         o_orient_change <= 1'b0;
      end else begin
         sleep_q <= i_sleep_state;
         o_orient_change <= orient_commit && !orient_clear;
         if (orient_commit && !orient_clear) begin
            o_orient_lockout <= cand_lock;
            if (!cand_lock) begin
               o_orient_lapo <= cand_lapo;
               o_orient_back <= cand_back;
            end
         end
      end
   end

   // freefall: all enabled axes low; motion: any enabled axis high
   wire any_en;
   wire ff_cond;
   wire mt_cond;
   wire ev_cond;
   wire held;
   wire ea_set;
   wire ea_drop;
   wire [7:0] mot_next;
   wire [7:0] mot_cnt;
   assign any_en = |axis_en;
   assign ff_cond = ~|(axis_en & axis_high);
   assign mt_cond = |(axis_en & axis_high);
   assign ev_cond = any_en &&
      (combine_or_select ? mt_cond : ff_cond);
   assign held = event_latch_en && motion_source[`OMED_MSRC_EA];
   assign o_event_active = motion_source[`OMED_MSRC_EA];

   // event sets once the counter reaches the programmed count
   // from the stored count: the read clear depends on ea_set, so using
   // the next count here would close a combinational loop
   assign ea_set = i_sample_tick && ev_cond &&
      ({1'b0, mot_cnt} + 9'h001 >=
      {1'b0, motion_debounce_count});
   // unlatched flag drops when the counter is back at zero
   assign ea_drop = i_sample_tick && !event_latch_en &&
      (mot_next == 8'h00);

   omed_debounce u_motion_db (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_tick(i_sample_tick && !held),
      .i_cond(ev_cond),
      .i_dec_mode(motion_threshold[`OMED_MTHS_DBMODE]),
      .i_limit(motion_debounce_count),
      .i_clear(!any_en ||
         (src_read && event_latch_en && !ea_set)),
      .o_next_count(mot_next),
      .o_count(mot_cnt)
   );

   // motion source register; a sample that sets the flag wins over a read
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         motion_source <= 8'h00;
      end else if (!any_en) begin
         motion_source <= 8'h00;
      end else if (ea_set && !held) begin
         motion_source <= {1'b1, 1'b0, axis_high[2], axis_neg[2],
            axis_high[1], axis_neg[1], axis_high[0], axis_neg[0]};
      end else if (src_read && event_latch_en && !ea_set) begin
         if (combine_or_select) begin
            motion_source <= 8'h00;
         end else begin
            motion_source[`OMED_MSRC_EA] <= 1'b0;
         end
      end else if (i_sample_tick && !held) begin
         // live, undebounced axis flags while nothing is held
         motion_source <= {!ea_drop && motion_source[`OMED_MSRC_EA],
            1'b0, axis_high[2], axis_neg[2] & axis_high[2],
            axis_high[1], axis_neg[1] & axis_high[1],
            axis_high[0], axis_neg[0] & axis_high[0]};
      end
   end

endmodule

// file: tb/omed_sample_src.sv
// sample source standing in for the sensing front end
// assumes the bench raises i_fire for one cycle per wanted sample
`timescale 1ns/1ps

module omed_sample_src (
   input wire i_clk_sys,
   input wire i_fire,
   input wire [7:0] i_x,
   input wire [7:0] i_y,
   input wire [7:0] i_z,
   output reg o_tick = 1'b0,
   output reg [7:0] o_x = 8'h00,
   output reg [7:0] o_y = 8'h00,
   output reg [7:0] o_z = 8'h00
);
   // axes valid with the tick only; inverted between ticks so stale use shows
   always @(negedge i_clk_sys) begin
      o_tick <= i_fire;
      if (i_fire) begin
         o_x <= i_x;
         o_y <= i_y;
         o_z <= i_z;
      end else begin
         o_x <= ~o_x;
         o_y <= ~o_y;
         o_z <= ~o_z;
      end
   end
endmodule

// file: tb/omed_checker.sv
// assertions on the ports of omed_top
// assumes one clock domain and the register map header
`timescale 1ns/1ps
`include "omed_regs.vh"

module omed_checker (
   input wire i_clk_sys,
   input wire i_reset,
   input wire [7:0] i_reg_addr,
   input wire i_reg_wr,
   input wire [7:0] i_reg_wdata,
   input wire i_reg_rd,
   input wire [7:0] o_reg_rdata,
   input wire i_sample_tick,
   input wire [1:0] i_osr_mode,
   input wire [2:0] i_output_sample_rate,
   input wire [9:0] o_orient_step,
   input wire [1:0] o_orient_lapo,
   input wire o_orient_change,
   input wire o_event_active
);
   reg [4:0] mcfg;
   wire src_rd = i_reg_rd && i_reg_addr == `OMED_ADDR_MOTION_SOURCE;
   // shadow of motion_config: latch, or, axis enables
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset)
         mcfg <= 5'h00;
      else if (i_reg_wr && i_reg_addr == `OMED_ADDR_MOTION_CONFIG)
         mcfg <= i_reg_wdata[7:3];
   end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);

   a_rdata_holds: assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata))
      else $error("read data moved without a read");
   a_fixed_angles: assert property (i_reg_rd && (i_reg_addr == 8'h13 ||
      i_reg_addr == 8'h14) |=> o_reg_rdata ==
      ($past(i_reg_addr) == 8'h13 ? 8'h44 : 8'h84))
      else $error("fixed angle register read wrong");
   a_step_slowest: assert property (i_osr_mode == `OMED_OSR_LP &&
      i_output_sample_rate == 3'h7 |=> o_orient_step == `OMED_STEP_160MS)
      else $error("slowest low power step wrong");
   a_ea_rise_cause: assert property ($rose(o_event_active) |->
      $past(i_sample_tick) && $past(mcfg[2:0]) != 3'h0)
      else $error("event flag rose without tick or axes");
   a_ea_fall_cause: assert property ($fell(o_event_active) |->
      $past(i_sample_tick) || $past(src_rd && mcfg[4]) ||
      $past(mcfg[2:0]) == 3'h0)
      else $error("event flag fell between samples");
   a_latch_read_clr: assert property (o_event_active && mcfg[4] && src_rd &&
      !i_sample_tick |=> !o_event_active)
      else $error("latched flag survived source read");
   a_open_read_keeps: assert property (!mcfg[4] && src_rd && !i_reg_wr &&
      !i_sample_tick |=> $stable(o_event_active))
      else $error("unlatched source read changed flag");
   a_lapo_on_tick: assert property ($changed(o_orient_lapo) |->
      $past(i_sample_tick))
      else $error("orientation moved between samples");
   a_change_after_tick: assert property (o_orient_change |->
      $past(i_sample_tick) || $past(i_sample_tick, 2))
      else $error("orientation change pulse without sample");

   c_event: cover property ($rose(o_event_active));
   c_orient: cover property (o_orient_change);
   c_latch_clr: cover property (mcfg[4] && src_rd && o_event_active);
endmodule

bind omed_top omed_checker omed_checker_inst (.i_clk_sys(i_clk_sys),
   .i_reset(i_reset), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
   .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
   .o_reg_rdata(o_reg_rdata), .i_sample_tick(i_sample_tick),
   .i_osr_mode(i_osr_mode), .i_output_sample_rate(i_output_sample_rate),
   .o_orient_step(o_orient_step), .o_orient_lapo(o_orient_lapo),
   .o_orient_change(o_orient_change), .o_event_active(o_event_active));

// file: tb/testbench.sv
// self-checking bench for omed_top through its byte register port
// assumes the sample source model drives ticks and axis samples
`timescale 1ns/1ps
`include "omed_regs.vh"

module testbench;
   reg i_clk_sys = 1'b0;
   reg i_reset = 1'b1;
   reg [7:0] i_reg_addr = 8'h00;
   reg i_reg_wr = 1'b0;
   reg [7:0] i_reg_wdata = 8'h00;
   reg i_reg_rd = 1'b0;
   reg i_sleep_state = 1'b0;
   reg [1:0] i_osr_mode = 2'h0;
   reg [2:0] i_output_sample_rate = 3'h0;
   reg fire = 1'b0;
   reg [7:0] ax = 8'h00;
   reg [7:0] ay = 8'h00;
   reg [7:0] az = 8'h00;
   wire tick;
   wire [7:0] xa, ya, za, rdata;
   wire [9:0] step;
   wire [1:0] lapo;
   wire back, lock, chg, ea;
   integer bad_count = 0;
   integer check_count = 0;
   integer cycles = 0;
   integer i, j;

   omed_sample_src omed_sample_src_inst (.i_clk_sys(i_clk_sys),
      .i_fire(fire), .i_x(ax), .i_y(ay), .i_z(az), .o_tick(tick),
      .o_x(xa), .o_y(ya), .o_z(za));
   omed_top omed_top_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
      .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
      .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .o_reg_rdata(rdata),
      .i_sample_tick(tick), .i_x_accel(xa), .i_y_accel(ya),
      .i_z_accel(za), .i_sleep_state(i_sleep_state),
      .i_osr_mode(i_osr_mode), .i_output_sample_rate(i_output_sample_rate),
      .o_orient_step(step), .o_orient_lapo(lapo), .o_orient_back(back),
      .o_orient_lockout(lock), .o_orient_change(chg),
      .o_event_active(ea));

   initial begin
      forever #5 i_clk_sys = ~i_clk_sys;
   end

   task check(input [63:0] what, input [9:0] exp, input [9:0] got);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("[ERR] %0s exp %h got %h", what, exp, got);
         end
      end
   endtask

   // one-cycle strobes, changed at the falling edge only
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(negedge i_clk_sys);
         i_reg_addr <= a;
         i_reg_wdata <= d;
         i_reg_wr <= 1'b1;
         @(negedge i_clk_sys);
         i_reg_wr <= 1'b0;
      end
   endtask

   task rd(input [7:0] a, input [7:0] exp);
      begin
         @(negedge i_clk_sys);
         i_reg_addr <= a;
         i_reg_rd <= 1'b1;
         @(negedge i_clk_sys);
         i_reg_rd <= 1'b0;
         check("rdata", {2'b00, exp}, {2'b00, rdata});
      end
   endtask

   // one idle cycle, then one sample through the source model
   task samp(input [7:0] x, input [7:0] y, input [7:0] z);
      begin
         @(negedge i_clk_sys);
         ax <= x;
         ay <= y;
         az <= z;
         fire <= 1'b1;
         @(negedge i_clk_sys);
         fire <= 1'b0;
         @(negedge i_clk_sys);
      end
   endtask

   task chk_ea(input e);
      begin
         check("ea", {9'h000, e}, {9'h000, ea});
      end
   endtask

   task do_reset;
      begin
         @(negedge i_clk_sys);
         i_reset <= 1'b1;
         @(negedge i_clk_sys);
         i_reset <= 1'b0;
      end
   endtask

   function [9:0] step_of(input [1:0] m, input [2:0] r);
      begin
         if (m == `OMED_OSR_HIRES)
            step_of = (r == 3'h0) ? `OMED_STEP_1P25MS : `OMED_STEP_2P5MS;
         else if (r < 3'h4)
            step_of = `OMED_STEP_1P25MS << r;
         else if (r == 3'h4 || m == `OMED_OSR_NORMAL)
            step_of = `OMED_STEP_20MS;
         else if (m == `OMED_OSR_LP && r != 3'h5)
            step_of = `OMED_STEP_160MS;
         else
            step_of = `OMED_STEP_80MS;
      end
   endfunction

   task results;
      begin
         if (bad_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask

   // hang guard, far above the few hundred cycles the run needs
   always @(posedge i_clk_sys) begin
      cycles = cycles + 1;
      if (cycles == 5000) begin
         bad_count = bad_count + 1;
         results;
      end
   end

   initial begin
      repeat (3) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      i_reset <= 1'b0;
      // reset values, fixed registers, unmapped place
      rd(8'h11, 8'h80);
      rd(8'h12, 8'h00);
      wr(8'h13, 8'hff);
      rd(8'h13, 8'h44);
      rd(8'h14, 8'h84);
      rd(8'h20, 8'h00);
      wr(8'h12, 8'ha5);
      rd(8'h12, 8'ha5);
      // every oversampling mode at every rate
      for (i = 0; i < 4; i = i + 1) begin
         for (j = 0; j < 8; j = j + 1) begin
            @(negedge i_clk_sys);
            i_osr_mode <= i[1:0];
            i_output_sample_rate <= j[2:0];
            repeat (2) @(negedge i_clk_sys);
            check("step", step_of(i[1:0],j[2:0]), step);
         end
      end
      // motion, unlatched, decrement mode, count 2, x only
      wr(8'h17, 8'h10);
      wr(8'h18, 8'h02);
      wr(8'h15, 8'h48);
      samp(8'h11, 8'h00, 8'h00);
      chk_ea(1'b0);
      samp(8'h11, 8'h00, 8'h00);
      chk_ea(1'b1);
      rd(8'h16, 8'h82);
      chk_ea(1'b1);
      samp(8'h00, 8'h00, 8'h00);
      chk_ea(1'b1);
      samp(8'h00, 8'h00, 8'h00);
      chk_ea(1'b0);
      // negative x, disabled y reads zero
      samp(8'hc0, 8'hc0, 8'h00);
      rd(8'h16, 8'h03);
      samp(8'h00, 8'h00, 8'h00);
      // motion, clear mode: drops on the first quiet sample
      wr(8'h17, 8'h90);
      samp(8'h40, 8'h00, 8'h00);
      samp(8'h40, 8'h00, 8'h00);
      chk_ea(1'b1);
      samp(8'hf0, 8'h00, 8'h00);
      chk_ea(1'b0);
      // freefall on all axes, boundary magnitude counts as low
      wr(8'h15, 8'h38);
      samp(8'h10, 8'h10, 8'hf0);
      samp(8'h10, 8'h10, 8'hf0);
      chk_ea(1'b1);
      samp(8'h40, 8'h10, 8'h10);
      chk_ea(1'b0);
      samp(8'h10, 8'h10, 8'h10);
      chk_ea(1'b0);
      samp(8'h10, 8'h10, 8'h10);
      chk_ea(1'b1);
      // latched motion: frozen flags, read clears, full delay again
      do_reset;
      wr(8'h17, 8'h10);
      wr(8'h18, 8'h02);
      wr(8'h15, 8'hc8);
      samp(8'h40, 8'h00, 8'h00);
      samp(8'h40, 8'h00, 8'h00);
      samp(8'h00, 8'h00, 8'h00);
      chk_ea(1'b1);
      rd(8'h16, 8'h82);
      rd(8'h16, 8'h00);
      chk_ea(1'b0);
      samp(8'h40, 8'h00, 8'h00);
      chk_ea(1'b0);
      samp(8'h40, 8'h00, 8'h00);
      chk_ea(1'b1);
      // no axis enabled: detector stays silent
      do_reset;
      wr(8'h15, 8'h40);
      wr(8'h17, 8'h10);
      samp(8'h40, 8'h40, 8'h40);
      chk_ea(1'b0);
      // orientation: disabled, then wake/sleep change restarts count
      wr(8'h12, 8'h02);
      repeat (3) samp(8'h40, 8'h00, 8'h00);
      check("lapo", 10'h000, {8'h00, lapo});
      wr(8'h11, 8'hc0);
      samp(8'h40, 8'h00, 8'h00);
      @(negedge i_clk_sys);
      i_sleep_state <= 1'b1;
      samp(8'h40, 8'h00, 8'h00);
      check("lapo1", 10'h000, {9'h000, lapo[1]});
      samp(8'h40, 8'h00, 8'h00);
      check("lapo1", 10'h001, {9'h000, lapo[1]});
      check("chg", 10'h001, {9'h000, chg});
      // z along gravity locks, then face down with x tilt sets back
      repeat (2) samp(8'h00, 8'h00, 8'h40);
      check("lock", 10'h001, {9'h000, lock});
      repeat (2) samp(8'h40, 8'h00, 8'he0);
      check("back", 10'h001, {9'h000, back});
      check("lock", 10'h000, {9'h000, lock});
      results;
   end
endmodule
